// ### rtl/pts_addr_decode.sv
// Purpose: Address range compare for the target end
// Assumes: address and command already captured
// Notes:   Purely combinational, result registered by the caller
`timescale 1ns/100ps
`default_nettype none
module pts_addr_decode (
  input  wire logic [31:0]                  addr,
  input  wire logic [3:0]                   cmd,
  output logic      [pts_pkg::NUM_BAR-1:0]  bar_hit,
  output logic                              rom_hit,
  output logic                              claim
);
  import pts_pkg::*;

  logic                is_mem;
  logic                is_io;
  logic                is_ack;
  logic [NUM_BAR-1:0]  bar_match;

  // Read line and read multiple behave as plain memory reads
  assign is_mem = (cmd == CMD_MEMRD) || (cmd == CMD_MRMULT) || (cmd == CMD_MRLINE);
  assign is_io  = (cmd == CMD_IORD);
  assign is_ack = (cmd == CMD_INTACK);

  for (genvar i = 0; i < NUM_BAR; i++)
  begin : g_bar
    assign bar_match[i] = ((addr & BAR_MASK[i]) == BAR_BASE[i])
                          && (BAR_IS_IO[i] ? is_io : is_mem);
  end

  assign rom_hit = is_mem && ((addr & ROM_MASK) == ROM_BASE);
  assign bar_hit = rom_hit ? '0 : bar_match;
  // Interrupt acknowledge is claimed with no window flagged
  assign claim   = is_ack || rom_hit || (|bar_match);
endmodule
`default_nettype wire

// ### rtl/pts_initiator.sv
// Purpose: PCI master plus local-side data source, far end
// Assumes: same PCI clock as the target, one read at a time
// Notes:   Local answer delay is set per read by the user
`timescale 1ns/100ps
`default_nettype none
module pts_initiator (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  pts_link_if.mst_mp       lnk,
  input  wire logic        start,
  input  wire logic [3:0]  cmd,
  input  wire logic [31:0] addr,
  input  wire logic [3:0]  be_n,
  input  wire logic [31:0] lcl_word,
  input  wire logic [3:0]  lcl_delay,
  output logic             busy,
  output logic             done,
  output logic [31:0]      rd_data,
  output logic             stopped,
  output logic             aborted
);
  import pts_pkg::*;

  pts_mstate_t  mst_ff;
  pts_mstate_t  nxt_mst;
  logic         frame_n_ff, nxt_frame_n;
  logic         irdy_n_ff, nxt_irdy_n;
  logic [3:0]   cbe_ff, nxt_cbe;
  logic [31:0]  mad_ff, nxt_mad;
  logic         mad_oe_n_ff, nxt_mad_oe_n;
  logic [2:0]   mcnt_ff, nxt_mcnt;
  logic         busy_ff, nxt_busy;
  logic         done_ff, nxt_done;
  logic [31:0]  rdata_ff, nxt_rdata;
  logic         stopped_ff, nxt_stopped;
  logic         aborted_ff, nxt_aborted;
  logic [3:0]   lcnt_ff, nxt_lcnt;
  logic         served_ff, nxt_served;
  logic         valid_n_ff, nxt_valid_n;
  logic [31:0]  ldata_ff, nxt_ldata;
  logic         disc_n_ff, nxt_disc_n;
  logic         lxfer;

  always_comb
  begin
    nxt_mst      = mst_ff;
    nxt_frame_n  = frame_n_ff;
    nxt_irdy_n   = irdy_n_ff;
    nxt_cbe      = cbe_ff;
    nxt_mad      = mad_ff;
    nxt_mad_oe_n = mad_oe_n_ff;
    nxt_mcnt     = mcnt_ff;
    nxt_busy     = busy_ff;
    nxt_done     = 1'b0;
    nxt_rdata    = rdata_ff;
    nxt_stopped  = stopped_ff;
    nxt_aborted  = aborted_ff;
    case (mst_ff)
      MS_IDLE:
      begin
        if (start)
        begin
          nxt_frame_n  = 1'b0;
          nxt_mad      = addr;
          nxt_mad_oe_n = 1'b0;
          nxt_cbe      = cmd;
          nxt_busy     = 1'b1;
          nxt_stopped  = 1'b0;
          nxt_aborted  = 1'b0;
          nxt_mst      = MS_ADDR;
        end
      end
      MS_ADDR:
      begin
        nxt_frame_n  = 1'b1;
        nxt_irdy_n   = 1'b0;
        nxt_mad_oe_n = 1'b1;
        nxt_cbe      = be_n;
        nxt_mcnt     = 3'h0;
        nxt_mst      = MS_DATA;
      end
      MS_DATA:
      begin
        nxt_mcnt = (mcnt_ff == 3'h7) ? mcnt_ff : mcnt_ff + 3'h1;
        if (!lnk.trdy_n)
        begin
          nxt_rdata = lnk.ad;
          nxt_done  = 1'b1;
          nxt_mst   = MS_END;
        end
        else if (!lnk.stop_n)
        begin
          nxt_stopped = 1'b1;
          nxt_done    = 1'b1;
          nxt_mst     = MS_END;
        end
        else if (lnk.devsel_n && mcnt_ff >= 3'(MABORT_CLK))
        begin
          nxt_aborted = 1'b1;
          nxt_done    = 1'b1;
          nxt_mst     = MS_END;
        end
      end
      MS_END:
      begin
        nxt_irdy_n = 1'b1;
        nxt_cbe    = CBE_IDLE;
        nxt_busy   = 1'b0;
        nxt_mst    = MS_IDLE;
      end
      default:
        nxt_mst = MS_IDLE;
    endcase
  end

  always_comb
  begin
    nxt_lcnt    = lcnt_ff;
    nxt_served  = served_ff;
    nxt_valid_n = valid_n_ff;
    nxt_ldata   = ldata_ff;
    nxt_disc_n  = disc_n_ff;
    lxfer       = !valid_n_ff && !lnk.local_accept_n;
    if (lnk.local_cycle_active_n)
    begin
      nxt_lcnt    = 4'h0;
      nxt_served  = 1'b0;
      nxt_valid_n = 1'b1;
      nxt_disc_n  = 1'b1;
    end
    else
    begin
      nxt_lcnt = (lcnt_ff == 4'hf) ? lcnt_ff : lcnt_ff + 4'h1;
      if (lxfer)
      begin
        nxt_served  = 1'b1;
        nxt_valid_n = 1'b1;
      end
      // Word lands delay+2 clocks after local frame, frame clock counted as one;
      // a word that would miss the limit asks the target to end instead
      else if (!served_ff && 5'(lcl_delay) + 5'h02 > 5'(LOCAL_FIRST_CLK))
        nxt_disc_n = 1'b0;
      else if (!served_ff && lcnt_ff >= lcl_delay)
      begin
        nxt_valid_n = 1'b0;
        nxt_ldata   = lcl_word;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      mst_ff      <= MS_IDLE;
      frame_n_ff  <= 1'b1;
      irdy_n_ff   <= 1'b1;
      cbe_ff      <= CBE_IDLE;
      mad_ff      <= WORD_RST;
      mad_oe_n_ff <= 1'b1;
      mcnt_ff     <= 3'h0;
      busy_ff     <= 1'b0;
      done_ff     <= 1'b0;
      rdata_ff    <= WORD_RST;
      stopped_ff  <= 1'b0;
      aborted_ff  <= 1'b0;
      lcnt_ff     <= 4'h0;
      served_ff   <= 1'b0;
      valid_n_ff  <= 1'b1;
      ldata_ff    <= WORD_RST;
      disc_n_ff   <= 1'b1;
    end
    else
    begin
      mst_ff      <= nxt_mst;
      frame_n_ff  <= nxt_frame_n;
      irdy_n_ff   <= nxt_irdy_n;
      cbe_ff      <= nxt_cbe;
      mad_ff      <= nxt_mad;
      mad_oe_n_ff <= nxt_mad_oe_n;
      mcnt_ff     <= nxt_mcnt;
      busy_ff     <= nxt_busy;
      done_ff     <= nxt_done;
      rdata_ff    <= nxt_rdata;
      stopped_ff  <= nxt_stopped;
      aborted_ff  <= nxt_aborted;
      lcnt_ff     <= nxt_lcnt;
      served_ff   <= nxt_served;
      valid_n_ff  <= nxt_valid_n;
      ldata_ff    <= nxt_ldata;
      disc_n_ff   <= nxt_disc_n;
    end
  end

  assign lnk.frame_n                    = frame_n_ff;
  assign lnk.irdy_n                     = irdy_n_ff;
  assign lnk.cbe_n                      = cbe_ff;
  assign lnk.m_ad_o                     = mad_ff;
  assign lnk.m_ad_oe_n                  = mad_oe_n_ff;
  assign lnk.local_data_valid_n         = valid_n_ff;
  assign lnk.local_read_data_in         = ldata_ff;
  assign lnk.local_disconnect_request_n = disc_n_ff;
  assign busy                           = busy_ff;
  assign done                           = done_ff;
  assign rd_data                        = rdata_ff;
  assign stopped                        = stopped_ff;
  assign aborted                        = aborted_ff;
endmodule
`default_nettype wire

// ### rtl/pts_link_if.sv
// Purpose: PCI bus and local-side link between the two ends
// Assumes: one master and one target share the bus
// Notes:   Undriven shared lines resolve to the pulled-up level
`timescale 1ns/100ps
`default_nettype none
interface pts_link_if;
  logic        frame_n;
  logic        irdy_n;
  logic [3:0]  cbe_n;
  logic [31:0] m_ad_o;
  logic        m_ad_oe_n;
  logic [31:0] t_ad_o;
  logic        t_ad_oe_n;
  logic        t_devsel_o;
  logic        t_trdy_o;
  logic        t_stop_o;
  logic        t_ctl_oe_n;
  logic [31:0] ad;
  logic        devsel_n;
  logic        trdy_n;
  logic        stop_n;
  logic        local_cycle_active_n;
  logic [3:0]  local_command_bus;
  logic [31:0] local_address_bus;
  logic        local_accept_n;
  logic        local_data_valid_n;
  logic [31:0] local_read_data_in;
  logic        local_disconnect_request_n;

  // Pull-ups stand in for floating lines
  assign ad       = !t_ad_oe_n ? t_ad_o : (!m_ad_oe_n ? m_ad_o : '1);
  assign devsel_n = t_ctl_oe_n | t_devsel_o;
  assign trdy_n   = t_ctl_oe_n | t_trdy_o;
  assign stop_n   = t_ctl_oe_n | t_stop_o;

  modport tgt_mp (
    input  frame_n, irdy_n, cbe_n, ad,
    input  local_data_valid_n, local_read_data_in, local_disconnect_request_n,
    output t_ad_o, t_ad_oe_n, t_devsel_o, t_trdy_o, t_stop_o, t_ctl_oe_n,
    output local_cycle_active_n, local_command_bus, local_address_bus,
    output local_accept_n
  );

  modport mst_mp (
    output frame_n, irdy_n, cbe_n, m_ad_o, m_ad_oe_n,
    output local_data_valid_n, local_read_data_in, local_disconnect_request_n,
    input  ad, devsel_n, trdy_n, stop_n,
    input  local_cycle_active_n, local_command_bus, local_address_bus,
    input  local_accept_n
  );
endinterface
`default_nettype wire

// ### rtl/pts_pkg.sv
// Purpose: Shared constants for the PCI target read sequencer
// Assumes: 33-class PCI bus clocked at 40 MHz, 32-bit address/data
// Notes:   Range windows are plain defaults, set per system
package pts_pkg;

  localparam int NUM_BAR = 6;

  // Bus commands, as seen on the command/byte-enable lines
  localparam logic [3:0] CMD_INTACK = 4'h0;
  localparam logic [3:0] CMD_IORD   = 4'h2;
  localparam logic [3:0] CMD_MEMRD  = 4'h6;
  localparam logic [3:0] CMD_MRMULT = 4'hc;
  localparam logic [3:0] CMD_MRLINE = 4'he;

  // Range windows, entry 0 is the lowest memory window
  localparam logic [NUM_BAR-1:0][31:0] BAR_BASE = {
    32'h0000_1000, 32'h5000_0000, 32'h4000_0000,
    32'h3000_0000, 32'h2000_0000, 32'h1000_0000};
  localparam logic [NUM_BAR-1:0][31:0] BAR_MASK = {
    32'hffff_ff00, 32'hffff_0000, 32'hffff_0000,
    32'hffff_0000, 32'hffff_0000, 32'hfff0_0000};
  localparam logic [NUM_BAR-1:0]       BAR_IS_IO = 6'h20;
  localparam logic [31:0]              ROM_BASE  = 32'h7000_0000;
  localparam logic [31:0]              ROM_MASK  = 32'hffff_0000;

  // Latency figures in PCI clocks
  localparam int LAT_FIRST_CLK   = 16;
  localparam int LAT_NEXT_CLK    = 8;
  localparam int LOCAL_FIRST_CLK = 12;
  localparam int LOCAL_NEXT_CLK  = 8;
  localparam int DEVSEL_CLK      = 3;
  localparam int MABORT_CLK      = 4;
  // Last count at which a local word still meets the first-phase limit
  localparam logic [4:0] LAT_STOP_CNT = 5'(LAT_FIRST_CLK - 3);
  localparam logic [4:0] LAT_CNT_MAX  = 5'h1f;
  localparam logic [4:0] LAT_CNT_ONE  = 5'h01;

  // Values after reset
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [3:0]  CBE_IDLE = 4'hf;

  typedef enum logic [3:0] {
    TS_IDLE   = 4'h0,
    TS_DECODE = 4'h1,
    TS_PREP   = 4'h2,
    TS_WAIT   = 4'h3,
    TS_PIPE   = 4'h4,
    TS_DATA   = 4'h5,
    TS_STOP   = 4'h6,
    TS_END    = 4'h7
  } pts_tstate_t;

  typedef enum logic [1:0] {
    MS_IDLE = 2'h0,
    MS_ADDR = 2'h1,
    MS_DATA = 2'h2,
    MS_END  = 2'h3
  } pts_mstate_t;

endpackage

// ### rtl/pts_target.sv
// Purpose: PCI target read sequencer, device end
// Assumes: single PCI clock, single data phase per read
// Notes:   Burst, write, and configuration cycles are not handled
//
// Operation
// - Master starts read: frame, address, command
// - Master releases address bus, keeps byte enables
// - Device drives bus before target-ready
// - Capture address and command at frame
// - Compare captured address against every range
// - Master drops frame, raises initiator-ready
// - Hit and local frame one clock after decode
// - ROM window hit replaces range hit
// - Interrupt acknowledge claimed without hit outputs
// - Local command and address with local frame
// - Enable control drivers one clock early
// - Device-select three clocks after address
// - Device-select and local accept together
// - Enable address/data drivers when claiming
// - Word moves when ready and accept meet
// - Drive word with target-ready two clocks later
// - End: controls high one clock, bus floats
// - Then drop local frame, hits, control drivers
// - First data phase within sixteen clocks
// - Local data within twelve, then eight clocks
// - Slow local side requests disconnect
// - Memory and I/O reads share sequence
`timescale 1ns/100ps
`default_nettype none
module pts_target (
  input  wire logic                         clk,
  input  wire logic                         sys_rst,
  pts_link_if.tgt_mp                        lnk,
  output logic      [pts_pkg::NUM_BAR-1:0]  range_hit,
  output logic                              rom_hit,
  output logic                              stop_seen
);
  import pts_pkg::*;

  pts_tstate_t         state_ff;
  pts_tstate_t         nxt_state;
  logic                frame_d_ff;
  logic [31:0]         addr_ff;
  logic [31:0]         nxt_addr;
  logic [3:0]          cmd_ff;
  logic [3:0]          nxt_cmd;
  logic [4:0]          lat_cnt_ff;
  logic [4:0]          nxt_lat_cnt;
  logic                lfrm_n_ff;
  logic                nxt_lfrm_n;
  logic [3:0]          lcmd_ff;
  logic [3:0]          nxt_lcmd;
  logic [31:0]         laddr_ff;
  logic [31:0]         nxt_laddr;
  logic                accept_n_ff;
  logic                nxt_accept_n;
  logic [NUM_BAR-1:0]  hit_ff;
  logic [NUM_BAR-1:0]  nxt_hit;
  logic                rom_ff;
  logic                nxt_rom;
  logic                devsel_ff;
  logic                nxt_devsel;
  logic                trdy_ff;
  logic                nxt_trdy;
  logic                stop_ff;
  logic                nxt_stop;
  logic                ctl_oe_n_ff;
  logic                nxt_ctl_oe_n;
  logic                ad_oe_n_ff;
  logic                nxt_ad_oe_n;
  logic [31:0]         stage1_ff;
  logic [31:0]         nxt_stage1;
  logic [31:0]         stage2_ff;
  logic [31:0]         nxt_stage2;
  logic                stopped_ff;
  logic                nxt_stopped;
  logic                xfer;
  logic [NUM_BAR-1:0]  dec_hit;
  logic                dec_rom;
  logic                dec_claim;

  pts_addr_decode u_dec (
    .addr    (addr_ff),
    .cmd     (cmd_ff),
    .bar_hit (dec_hit),
    .rom_hit (dec_rom),
    .claim   (dec_claim)
  );

  always_comb
  begin
    nxt_state    = state_ff;
    nxt_addr     = addr_ff;
    nxt_cmd      = cmd_ff;
    nxt_lfrm_n   = lfrm_n_ff;
    nxt_lcmd     = lcmd_ff;
    nxt_laddr    = laddr_ff;
    nxt_accept_n = accept_n_ff;
    nxt_hit      = hit_ff;
    nxt_rom      = rom_ff;
    nxt_devsel   = devsel_ff;
    nxt_trdy     = trdy_ff;
    nxt_stop     = stop_ff;
    nxt_ctl_oe_n = ctl_oe_n_ff;
    nxt_ad_oe_n  = ad_oe_n_ff;
    nxt_stage1   = stage1_ff;
    nxt_stage2   = stage2_ff;
    nxt_stopped  = stopped_ff;
    xfer         = !lnk.local_data_valid_n && !accept_n_ff;
    // Counts clocks since the address phase, saturating
    if (state_ff == TS_IDLE)
      nxt_lat_cnt = LAT_CNT_ONE;
    else if (lat_cnt_ff == LAT_CNT_MAX)
      nxt_lat_cnt = lat_cnt_ff;
    else
      nxt_lat_cnt = lat_cnt_ff + LAT_CNT_ONE;
    case (state_ff)
      TS_IDLE:
      begin
        // Only a fresh frame edge starts a cycle, so a held frame is not re-taken
        if (!lnk.frame_n && frame_d_ff)
        begin
          nxt_addr    = lnk.ad;
          nxt_cmd     = lnk.cbe_n;
          nxt_stopped = 1'b0;
          nxt_state   = TS_DECODE;
        end
      end
      TS_DECODE:
      begin
        if (dec_claim)
        begin
          nxt_hit      = dec_hit;
          nxt_rom      = dec_rom;
          nxt_lfrm_n   = 1'b0;
          nxt_lcmd     = cmd_ff;
          nxt_laddr    = addr_ff;
          nxt_ctl_oe_n = 1'b0;
          nxt_devsel   = 1'b1;
          nxt_trdy     = 1'b1;
          nxt_stop     = 1'b1;
          nxt_state    = TS_PREP;
        end
        else
          nxt_state = TS_IDLE;
      end
      TS_PREP:
      begin
        nxt_devsel   = 1'b0;
        nxt_accept_n = 1'b0;
        nxt_ad_oe_n  = 1'b0;
        nxt_state    = TS_WAIT;
      end
      TS_WAIT:
      begin
        if (xfer)
        begin
          nxt_stage1   = lnk.local_read_data_in;
          nxt_accept_n = 1'b1;
          nxt_state    = TS_PIPE;
        end
        else if (!lnk.local_disconnect_request_n || lat_cnt_ff >= LAT_STOP_CNT)
        begin
          // Stop in time rather than overrun the first-phase limit
          nxt_stop     = 1'b0;
          nxt_accept_n = 1'b1;
          nxt_stopped  = 1'b1;
          nxt_state    = TS_STOP;
        end
      end
      TS_PIPE:
      begin
        nxt_stage2 = stage1_ff;
        nxt_trdy   = 1'b0;
        nxt_state  = TS_DATA;
      end
      TS_DATA:
      begin
        // Master wait states simply hold the word and target-ready
        if (!lnk.irdy_n)
        begin
          nxt_trdy    = 1'b1;
          nxt_devsel  = 1'b1;
          nxt_ad_oe_n = 1'b1;
          nxt_state   = TS_END;
        end
      end
      TS_STOP:
      begin
        nxt_stop    = 1'b1;
        nxt_devsel  = 1'b1;
        nxt_ad_oe_n = 1'b1;
        nxt_state   = TS_END;
      end
      TS_END:
      begin
        nxt_lfrm_n   = 1'b1;
        nxt_hit      = '0;
        nxt_rom      = 1'b0;
        nxt_ctl_oe_n = 1'b1;
        nxt_state    = TS_IDLE;
      end
      default:
        nxt_state = TS_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_ff    <= TS_IDLE;
      frame_d_ff  <= 1'b1;
      addr_ff     <= WORD_RST;
      cmd_ff      <= CMD_INTACK;
      lat_cnt_ff  <= LAT_CNT_ONE;
      lfrm_n_ff   <= 1'b1;
      lcmd_ff     <= CMD_INTACK;
      laddr_ff    <= WORD_RST;
      accept_n_ff <= 1'b1;
      hit_ff      <= '0;
      rom_ff      <= 1'b0;
      devsel_ff   <= 1'b1;
      trdy_ff     <= 1'b1;
      stop_ff     <= 1'b1;
      ctl_oe_n_ff <= 1'b1;
      ad_oe_n_ff  <= 1'b1;
      stage1_ff   <= WORD_RST;
      stage2_ff   <= WORD_RST;
      stopped_ff  <= 1'b0;
    end
    else
    begin
      state_ff    <= nxt_state;
      frame_d_ff  <= lnk.frame_n;
      addr_ff     <= nxt_addr;
      cmd_ff      <= nxt_cmd;
      lat_cnt_ff  <= nxt_lat_cnt;
      lfrm_n_ff   <= nxt_lfrm_n;
      lcmd_ff     <= nxt_lcmd;
      laddr_ff    <= nxt_laddr;
      accept_n_ff <= nxt_accept_n;
      hit_ff      <= nxt_hit;
      rom_ff      <= nxt_rom;
      devsel_ff   <= nxt_devsel;
      trdy_ff     <= nxt_trdy;
      stop_ff     <= nxt_stop;
      ctl_oe_n_ff <= nxt_ctl_oe_n;
      ad_oe_n_ff  <= nxt_ad_oe_n;
      stage1_ff   <= nxt_stage1;
      stage2_ff   <= nxt_stage2;
      stopped_ff  <= nxt_stopped;
    end
  end

  assign lnk.t_ad_o                = stage2_ff;
  assign lnk.t_ad_oe_n             = ad_oe_n_ff;
  assign lnk.t_devsel_o            = devsel_ff;
  assign lnk.t_trdy_o              = trdy_ff;
  assign lnk.t_stop_o              = stop_ff;
  assign lnk.t_ctl_oe_n            = ctl_oe_n_ff;
  assign lnk.local_cycle_active_n  = lfrm_n_ff;
  assign lnk.local_command_bus     = lcmd_ff;
  assign lnk.local_address_bus     = laddr_ff;
  assign lnk.local_accept_n        = accept_n_ff;
  assign range_hit                 = hit_ff;
  assign rom_hit                   = rom_ff;
  assign stop_seen                 = stopped_ff;
endmodule
`default_nettype wire

// ### testbench/pci_target_read_sequencer_tb.sv
// Purpose: Bench joining master end and target end
// Assumes: 40 MHz clock, inputs driven 1 ns after the edge
// Notes:   Fault injection by a second link is left out for size
`timescale 1ns/100ps
`default_nettype none
module pci_target_read_sequencer_tb;
  import pts_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic start = 1'b0;
  logic [3:0] cmd = CMD_MEMRD;
  logic [31:0] addr = WORD_RST;
  logic [3:0] lcl_delay = 4'h1;
  logic [31:0] lcl_word = WORD_RST;
  logic [5:0] range_hit;
  logic rom_hit, stop_seen, busy, done, stopped, aborted;
  logic [31:0] rd_data;
  int n_errors = 0;
  int tests_run = 0;

  always #12.5 clk = ~clk;
  pts_link_if lnk ();
  pts_target i_pts_target (.clk(clk), .sys_rst(sys_rst), .lnk(lnk), .range_hit(range_hit),
    .rom_hit(rom_hit), .stop_seen(stop_seen));
  pts_initiator i_pts_initiator (.clk(clk), .sys_rst(sys_rst), .lnk(lnk), .start(start),
    .cmd(cmd), .addr(addr), .be_n(4'h0), .lcl_word(lcl_word), .lcl_delay(lcl_delay),
    .busy(busy), .done(done), .rd_data(rd_data), .stopped(stopped), .aborted(aborted));
  pts_chk_sva i_pts_chk_sva (.clk(clk), .sys_rst(sys_rst), .frame_n(lnk.frame_n),
    .cbe_n(lnk.cbe_n), .ad(lnk.ad), .devsel_n(lnk.devsel_n), .trdy_n(lnk.trdy_n),
    .stop_n(lnk.stop_n), .t_ad_oe_n(lnk.t_ad_oe_n), .t_ctl_oe_n(lnk.t_ctl_oe_n),
    .local_cycle_active_n(lnk.local_cycle_active_n), .local_command_bus(lnk.local_command_bus),
    .local_address_bus(lnk.local_address_bus), .local_accept_n(lnk.local_accept_n),
    .local_data_valid_n(lnk.local_data_valid_n), .local_read_data_in(lnk.local_read_data_in),
    .local_disconnect_request_n(lnk.local_disconnect_request_n));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // One read; hits sampled while the local frame is low
  task automatic rd(input logic [3:0] c, input logic [31:0] a, input logic [3:0] d,
                    input logic [5:0] eh, input logic er, input logic ea, input logic es);
    logic [5:0] sh;
    logic sr;
    int k;
    sh = '0;
    sr = 1'b0;
    cmd = c;
    addr = a;
    lcl_delay = d;
    lcl_word = a ^ 32'h5a5a_0f0f;
    start = 1'b1;
    @(posedge clk) #1;
    start = 1'b0;
    for (k = 0; k < 60 && done !== 1'b1; k++)
    begin
      if (lnk.local_cycle_active_n === 1'b0)
      begin
        sh = range_hit;
        sr = rom_hit;
      end
      @(posedge clk) #1;
    end
    check(32'(k < 60), 32'h0000_0001);
    check(32'(sh), 32'(eh));
    check(32'(sr), 32'(er));
    check(32'(aborted), 32'(ea));
    check(32'(stopped), 32'(es));
    if (!ea && !es)
      check(rd_data, lcl_word);
    for (k = 0; k < 5 && busy !== 1'b0; k++)
      @(posedge clk) #1;
    check(32'(stop_seen), 32'(es));
    check(32'({range_hit, rom_hit}), 32'h0000_0000);
    $display("Test done cmd %h addr %h", c, a);
  endtask

  initial
  begin
    #(25 * 4000);
    n_errors++;
    complete_run();
  end

  initial
  begin
    repeat (8) @(posedge clk);
    #1 sys_rst = 1'b0;
    @(posedge clk) #1;
    rd(CMD_MEMRD, 32'h1000_0004, 4'h1, 6'h01, 1'b0, 1'b0, 1'b0);
    rd(CMD_IORD, 32'h0000_1010, 4'h1, 6'h20, 1'b0, 1'b0, 1'b0);
    rd(CMD_MRLINE, 32'h3000_0020, 4'h3, 6'h04, 1'b0, 1'b0, 1'b0);
    rd(CMD_MRMULT, 32'h5000_fffc, 4'h2, 6'h10, 1'b0, 1'b0, 1'b0);
    rd(CMD_MEMRD, 32'h7000_0010, 4'h1, 6'h00, 1'b1, 1'b0, 1'b0);
    rd(CMD_INTACK, 32'h2000_0000, 4'h1, 6'h00, 1'b0, 1'b0, 1'b0);
    rd(4'ha, 32'h1000_0000, 4'h1, 6'h00, 1'b0, 1'b1, 1'b0);
    rd(CMD_MEMRD, 32'h8000_0000, 4'h1, 6'h00, 1'b0, 1'b1, 1'b0);
    // Latest local word that still meets the first-phase limit
    rd(CMD_MEMRD, 32'h4000_0100, 4'ha, 6'h08, 1'b0, 1'b0, 1'b0);
    rd(CMD_MEMRD, 32'h4000_0104, 4'hb, 6'h08, 1'b0, 1'b0, 1'b1);
    rd(CMD_MEMRD, 32'h2000_0040, 4'hd, 6'h02, 1'b0, 1'b0, 1'b1);
    rd(CMD_MEMRD, 32'h1000_0008, 4'h1, 6'h01, 1'b0, 1'b0, 1'b0);
    complete_run();
  end
endmodule
`default_nettype wire

// ### testbench/pts_chk_sva.sv
// Purpose: Timing checks on the link between the two ends
// Assumes: single clock, sync reset, one data phase per read
// Notes:   Hit outputs are judged by the bench, not here
`timescale 1ns/100ps
`default_nettype none
module pts_chk_sva
  import pts_pkg::*;
(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        frame_n,
  input wire logic [3:0]  cbe_n,
  input wire logic [31:0] ad,
  input wire logic        devsel_n,
  input wire logic        trdy_n,
  input wire logic        stop_n,
  input wire logic        t_ad_oe_n,
  input wire logic        t_ctl_oe_n,
  input wire logic        local_cycle_active_n,
  input wire logic [3:0]  local_command_bus,
  input wire logic [31:0] local_address_bus,
  input wire logic        local_accept_n,
  input wire logic        local_data_valid_n,
  input wire logic [31:0] local_read_data_in,
  input wire logic        local_disconnect_request_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  claim_timing_a: assert property ($fell(local_cycle_active_n) |->
    $past(frame_n, 2) == 1'b0 ##1 (!devsel_n && !local_accept_n))
    else $error("claim timing wrong");
  ctl_early_a: assert property ($fell(local_cycle_active_n) |->
    !t_ctl_oe_n && devsel_n) else $error("control drivers not early");
  ad_drive_a: assert property ($fell(devsel_n) |-> !t_ad_oe_n && trdy_n)
    else $error("ad not driven at claim");
  word_out_a: assert property (!local_data_valid_n && !local_accept_n |=> ##1
    (!trdy_n && ad == $past(local_read_data_in, 2))) else $error("word not on bus");
  end_seq_a: assert property (!trdy_n |=> (trdy_n && devsel_n && stop_n &&
    !t_ctl_oe_n && t_ad_oe_n) ##1 (t_ctl_oe_n && local_cycle_active_n))
    else $error("end sequence wrong");
  local_hold_a: assert property (!local_cycle_active_n && !$fell(local_cycle_active_n)
    |-> $stable(local_command_bus) && $stable(local_address_bus))
    else $error("local bus moved");
  first_lat_a: assert property ($fell(local_cycle_active_n) |->
    ##[1:13] (!trdy_n || !stop_n)) else $error("first phase too late");
  local_bus_a: assert property ($fell(local_cycle_active_n) |->
    local_command_bus == $past(cbe_n, 2) && local_address_bus == $past(ad, 2))
    else $error("local cmd or addr wrong");
  disc_stop_a: assert property ($fell(local_disconnect_request_n) |=>
    !stop_n ##1 stop_n) else $error("disconnect not honoured");
endmodule
`default_nettype wire
